// >>> hw/lgl_lut_mem.sv
// Purpose: colour table storage with registered read data
// Assumes: write and reads on the same clock
// Notes:   a read of a word written the same cycle returns the old word
`timescale 1ns/100ps
`default_nettype none
module lgl_lut_mem
    import lgl_pkg::*;
#(
    parameter int DEPTH = 256
) (
    input  wire logic pclk,
    input  wire logic presetn,
    lgl_lut_if.mem    lut
);
    logic [23:0]      mem_q [DEPTH];
    logic [3:0][23:0] rd_r;

    // storage write
    always_ff @(posedge pclk) begin
        if (lut.wr_en) begin
            mem_q[lut.wr_addr] <= lut.wr_data;
        end
    end

    // registered read ports
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_r <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                rd_r[i] <= mem_q[lut.rd_addr[i]];
            end
        end
    end

    assign lut.rd_data = rd_r;
endmodule
`default_nettype wire

// >>> hw/lgl_top.sv
// Purpose: graphics blend, shared colour table and gamma on the primary lcd output
// Assumes: apb zero-wait slave, dma read port with one request outstanding
// Notes:   pixel path latency is four clocks
`timescale 1ns/100ps
`default_nettype none
`include "lgl_params.svh"
module lgl_top
    import lgl_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        frame_start,
    input  wire logic        px_valid,
    input  wire logic [23:0] video_rgb,
    input  wire logic [7:0]  gfx_index,
    output var  logic        lcd_valid,
    output var  logic [23:0] lcd_rgb,
    output var  logic        dma_req,
    output var  logic [31:0] dma_addr,
    input  wire logic        dma_ack,
    input  wire logic        dma_rvalid,
    input  wire logic [31:0] dma_rdata
);
    lgl_lut_if lut ();

    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    logic [31:0] cfg_r, cfg_nxt, attr_r, attr_nxt, base_r, base_nxt;
    logic [31:0] size_r, size_nxt, opa_r, opa_nxt, tbase_r, tbase_nxt;
    logic [7:0]  tidx_r, tidx_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic        loaded_r, loaded_nxt;
    lgl_dma_e    dma_st_r, dma_st_nxt;
    logic [7:0]  dma_cnt_r, dma_cnt_nxt;
    logic        dma_req_r, dma_req_nxt;
    logic [31:0] dma_addr_r, dma_addr_nxt;
    logic        setup, wr_go, sw_tbl_wr, gfx_on, dma_busy;

    assign setup     = psel && !penable;
    assign wr_go     = psel && penable && pready_r && pwrite && !pslverr_r;
    assign gfx_on    = attr_r[`LGL_ATTR_EN_BIT];
    assign dma_busy  = (dma_st_r != LGL_DMA_IDLE);
    // software table write lands only with the pipeline running
    assign sw_tbl_wr = wr_go && (paddr == `LGL_OFS_TBL_DATA) && gfx_on;

    // decode of a register read, zero for unmapped words
    function automatic logic [31:0] rd_word(input logic [11:0] a);
        unique case (a)
            `LGL_OFS_CONFIG:    rd_word = cfg_r;
            `LGL_OFS_ATTR:      rd_word = attr_r;
            `LGL_OFS_BASE:      rd_word = base_r;
            `LGL_OFS_SIZE:      rd_word = size_r;
            `LGL_OFS_OPACITY:   rd_word = opa_r;
            `LGL_OFS_TBL_INDEX: rd_word = {24'h000000, tidx_r};
            `LGL_OFS_TBL_BASE:  rd_word = tbase_r;
            `LGL_OFS_STATUS:    rd_word = {30'h0, dma_busy, loaded_r};
            default:            rd_word = 32'h0000_0000;
        endcase
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a <= `LGL_OFS_TBL_BASE) && (a[1:0] == 2'h0);
    endfunction

    // ---------------------------------------------------------------
    // apb slave
    // ---------------------------------------------------------------
    // answer in the first access cycle; data word fetched during setup
    always_comb begin
        pready_nxt  = setup;
        prdata_nxt  = setup && !pwrite ? rd_word(paddr) : prdata_r;
        pslverr_nxt = setup && (!mapped(paddr) || (pwrite && paddr == `LGL_OFS_STATUS)
                      || (pwrite && paddr == `LGL_OFS_TBL_DATA && dma_busy));
        cfg_nxt     = cfg_r;
        attr_nxt    = attr_r;
        base_nxt    = base_r;
        size_nxt    = size_r;
        opa_nxt     = opa_r;
        tbase_nxt   = tbase_r;
        tidx_nxt    = tidx_r;
        if (wr_go) begin
            unique case (paddr)
                `LGL_OFS_CONFIG:    cfg_nxt   = {28'h0000000, pwdata[3:0]};
                `LGL_OFS_ATTR:      attr_nxt  = {4'h0, pwdata[27:26], 25'h0,
                                                 pwdata[0]};
                `LGL_OFS_BASE:      base_nxt  = pwdata;
                `LGL_OFS_SIZE:      size_nxt  = {4'h0, pwdata[27:16], 5'h00, pwdata[10:0]};
                `LGL_OFS_OPACITY:   opa_nxt   = {24'h000000, pwdata[7:0]};
                `LGL_OFS_TBL_INDEX: tidx_nxt  = pwdata[7:0];
                `LGL_OFS_TBL_BASE:  tbase_nxt = pwdata;
                default: ;
            endcase
        end
        if (sw_tbl_wr) begin
            tidx_nxt = tidx_r + 8'h01;  // auto-increment for burst loads
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r     <= `LGL_RST_WORD;
            attr_r    <= `LGL_RST_WORD;
            base_r    <= `LGL_RST_WORD;
            size_r    <= `LGL_RST_WORD;
            opa_r     <= `LGL_RST_WORD;
            tbase_r   <= `LGL_RST_WORD;
            tidx_r    <= 8'h00;
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            cfg_r     <= cfg_nxt;
            attr_r    <= attr_nxt;
            base_r    <= base_nxt;
            size_r    <= size_nxt;
            opa_r     <= opa_nxt;
            tbase_r   <= tbase_nxt;
            tidx_r    <= tidx_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ---------------------------------------------------------------
    // table fetch by dma
    // ---------------------------------------------------------------
    // start at frame start while the pipeline runs; mode zero every frame
    always_comb begin
        dma_st_nxt   = dma_st_r;
        dma_cnt_nxt  = dma_cnt_r;
        dma_req_nxt  = dma_req_r;
        dma_addr_nxt = dma_addr_r;
        loaded_nxt   = loaded_r;
        unique case (dma_st_r)
            LGL_DMA_IDLE: begin
                if (frame_start && gfx_on && (!loaded_r ||
                    cfg_r[`LGL_CFG_LOAD_HI:`LGL_CFG_LOAD_LO] == `LGL_LOAD_EVERY)) begin
                    dma_st_nxt   = LGL_DMA_REQ;
                    dma_cnt_nxt  = 8'h00;
                    dma_req_nxt  = 1'b1;
                    dma_addr_nxt = tbase_r;
                end
            end
            LGL_DMA_REQ: begin
                if (dma_ack) begin
                    dma_st_nxt  = LGL_DMA_WAIT;
                    dma_req_nxt = 1'b0;
                end
            end
            LGL_DMA_WAIT: begin
                if (dma_rvalid) begin
                    dma_cnt_nxt  = dma_cnt_r + 8'h01;
                    dma_addr_nxt = dma_addr_r + 32'h0000_0004;
                    if (dma_cnt_r == 8'hFF) begin
                        dma_st_nxt = LGL_DMA_IDLE;
                        loaded_nxt = gfx_on;  // a fetch ended with pipeline off is void
                    end else begin
                        dma_st_nxt  = LGL_DMA_REQ;
                        dma_req_nxt = 1'b1;
                    end
                end
            end
            default: dma_st_nxt = LGL_DMA_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_st_r   <= LGL_DMA_IDLE;
            dma_cnt_r  <= 8'h00;
            dma_req_r  <= 1'b0;
            dma_addr_r <= 32'h0000_0000;
            loaded_r   <= 1'b0;
        end else begin
            dma_st_r   <= dma_st_nxt;
            dma_cnt_r  <= dma_cnt_nxt;
            dma_req_r  <= dma_req_nxt;
            dma_addr_r <= dma_addr_nxt;
            loaded_r   <= loaded_nxt;
        end
    end

    // shared table write port, dma or software
    assign lut.wr_en   = (dma_st_r == LGL_DMA_WAIT && dma_rvalid && gfx_on) || sw_tbl_wr;
    assign lut.wr_addr = dma_busy ? dma_cnt_r : tidx_r;
    assign lut.wr_data = dma_busy ? dma_rdata[23:0] : pwdata[23:0];

    lgl_lut_mem #(.DEPTH(`LGL_TBL_DEPTH)) u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .lut     (lut)
    );

    // ---------------------------------------------------------------
    // pixel path
    // ---------------------------------------------------------------
    // one channel of graphics over video; opacity zero leaves video exact
    function automatic logic [7:0] blend(input logic [7:0] g, input logic [7:0] v,
                                         input logic [7:0] a);
        logic [16:0] s;
        // products widened first so the graphics share is not cut to eight bits
        s = {1'b0, 16'(g) * 16'(a)} + 17'(v) * (17'h100 - 17'(a));
        blend = s[15:8];
    endfunction

    logic        v1_r, v1_nxt, v2_r, v2_nxt, v3_r, v3_nxt, ov_r, ov_nxt;
    lgl_rgb_t    vid1_r, vid1_nxt, mix_r, mix_nxt, orgb_r, orgb_nxt, mix2_r;
    logic [7:0]  alpha;

    // bitmap stage shows through only when enabled and above video
    assign alpha = (gfx_on && attr_r[`LGL_ATTR_POS_HI:`LGL_ATTR_POS_LO] != `LGL_POS_BOTTOM)
                   ? opa_r[`LGL_OPA_HI:`LGL_OPA_LO] : 8'h00;

    // port 0 bitmap index ports 1..3 blended channels for gamma
    assign lut.rd_addr = {mix_r[7:0], mix_r[15:8], mix_r[23:16], gfx_index};

    always_comb begin
        v1_nxt   = px_valid;
        vid1_nxt = video_rgb;
        v2_nxt   = v1_r;
        mix_nxt  = mix_r;  // held on invalid cycles
        if (v2_nxt) begin
            mix_nxt = {blend(lut.rd_data[0][23:16], vid1_r[23:16], alpha),
                       blend(lut.rd_data[0][15:8],  vid1_r[15:8],  alpha),
                       blend(lut.rd_data[0][7:0],   vid1_r[7:0],   alpha)};
        end
        v3_nxt   = v2_r;
        ov_nxt   = v3_r;
        orgb_nxt = cfg_r[`LGL_CFG_GAMMA_BIT]
                   ? {lut.rd_data[1][23:16], lut.rd_data[2][15:8], lut.rd_data[3][7:0]}
                   : mix2_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            v1_r   <= 1'b0;
            vid1_r <= '0;
            v2_r   <= 1'b0;
            mix_r  <= '0;
            mix2_r <= '0;
            v3_r   <= 1'b0;
            ov_r   <= 1'b0;
            orgb_r <= '0;
        end else begin
            v1_r   <= v1_nxt;
            vid1_r <= vid1_nxt;
            v2_r   <= v2_nxt;
            mix_r  <= mix_nxt;
            mix2_r <= mix_r;
            v3_r   <= v3_nxt;
            ov_r   <= ov_nxt;
            orgb_r <= orgb_nxt;
        end
    end

    // outputs straight from flip-flops
    assign prdata    = prdata_r;
    assign pready    = pready_r;
    assign pslverr   = pslverr_r;
    assign dma_req   = dma_req_r;
    assign dma_addr  = dma_addr_r;
    assign lcd_valid = ov_r;
    assign lcd_rgb   = orgb_r;
endmodule
`default_nettype wire

// >>> shared/lgl_lut_if.sv
// Purpose: carrier between the controller and the colour table memory
// Assumes: one write port, four read ports
// Notes:   read port 0 bitmap lookup, ports 1..3 gamma red, green, blue
`timescale 1ns/100ps
`default_nettype none
interface lgl_lut_if;
    logic              wr_en;
    logic [7:0]        wr_addr;
    logic [23:0]       wr_data;
    logic [3:0][7:0]   rd_addr;
    logic [3:0][23:0]  rd_data;
    modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
    modport user (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
endinterface
`default_nettype wire

// >>> shared/lgl_params.svh
// Purpose: offsets, field positions, reset values and sizes of the gamma table block
// Assumes: included by bare name from every file that needs a constant
// Notes:   definitions only
`ifndef LGL_PARAMS_SVH
`define LGL_PARAMS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define LGL_OFS_CONFIG      12'h000
`define LGL_OFS_ATTR        12'h004
`define LGL_OFS_BASE        12'h008
`define LGL_OFS_SIZE        12'h00C
`define LGL_OFS_OPACITY     12'h010
`define LGL_OFS_TBL_INDEX   12'h014
`define LGL_OFS_TBL_DATA    12'h018
`define LGL_OFS_STATUS      12'h01C
`define LGL_OFS_TBL_BASE    12'h020

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define LGL_CFG_LOAD_HI     2
`define LGL_CFG_LOAD_LO     1
`define LGL_CFG_GAMMA_BIT   3
`define LGL_ATTR_EN_BIT     0
`define LGL_ATTR_POS_HI     27
`define LGL_ATTR_POS_LO     26
`define LGL_SIZE_H_HI       27
`define LGL_SIZE_H_LO       16
`define LGL_SIZE_W_HI       10
`define LGL_SIZE_W_LO       0
`define LGL_OPA_HI          7
`define LGL_OPA_LO          0
`define LGL_ST_LOADED_BIT   0
`define LGL_ST_BUSY_BIT     1

// ---------------------------------------------------------------
// reset values and encodings
// ---------------------------------------------------------------
`define LGL_RST_WORD        32'h0000_0000
`define LGL_LOAD_EVERY      2'h0
`define LGL_POS_BOTTOM      2'h0
`define LGL_TBL_DEPTH       256
`define LGL_TBL_WIDTH       24

`endif

// >>> shared/lgl_pkg.sv
// Purpose: types shared by the gamma table block
// Assumes: nothing
// Notes:   constants live in lgl_params.svh
package lgl_pkg;
    typedef logic [7:0]  lgl_idx_t;
    typedef logic [23:0] lgl_rgb_t;
    typedef enum logic [1:0] {
        LGL_DMA_IDLE = 2'b00,
        LGL_DMA_REQ  = 2'b01,
        LGL_DMA_WAIT = 2'b10
    } lgl_dma_e;
endpackage

// >>> verif/lgl_panel.sv
// Purpose: display panel on the primary lcd output
// Assumes: takes one pixel per lcd_valid cycle
// Notes:   keeps the last pixel and a running count
`timescale 1ns/100ps
`default_nettype none
module lgl_panel (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        lcd_valid,
    input  wire logic [23:0] lcd_rgb,
    output var  logic [23:0] got_rgb,
    output var  logic [15:0] got_cnt
);
    // latch each valid pixel as the glass would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            got_rgb <= 24'h000000;
            got_cnt <= 16'h0000;
        end else if (lcd_valid) begin
            got_rgb <= lcd_rgb;
            got_cnt <= got_cnt + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// >>> verif/lgl_props.sv
// Purpose: port-level checks for the gamma table block
// Assumes: bound to lgl_top, one clock domain
// Notes:   apb zero wait state, pixel path four clocks
`timescale 1ns/100ps
`default_nettype none
module lgl_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        px_valid,
    input wire logic        lcd_valid,
    input wire logic        dma_req,
    input wire logic [31:0] dma_addr,
    input wire logic        dma_ack
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ---------------------------------------------------------------
    // register port
    // ---------------------------------------------------------------
    apb_ready_a: assert property (psel && !penable |=> pready && penable)
        else $error("ready missing after setup");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_err_a: assert property (psel && !penable && paddr > 12'h020 |=> pslverr)
        else $error("unmapped address not refused");
    // ---------------------------------------------------------------
    // pixel path and table fetch
    // ---------------------------------------------------------------
    pix_lat_a: assert property (px_valid |-> ##4 lcd_valid)
        else $error("pixel latency not four");
    pix_gap_a: assert property (!px_valid |-> ##4 !lcd_valid)
        else $error("output pixel without input pixel");
    dma_hold_a: assert property (dma_req && !dma_ack |=> dma_req && $stable(dma_addr))
        else $error("fetch request dropped early");
    dma_drop_a: assert property (dma_ack |=> !dma_req)
        else $error("fetch request held after ack");
    cover property (dma_ack);
    cover property (lcd_valid);
    cover property (pslverr);
endmodule
bind lgl_top lgl_props lgl_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .px_valid(px_valid), .lcd_valid(lcd_valid), .dma_req(dma_req),
    .dma_addr(dma_addr), .dma_ack(dma_ack));
`default_nettype wire

// >>> verif/tb.sv
// Purpose: self-checking bench of the gamma table block
// Assumes: apb master tasks, dma memory answering at once
// Notes:   table entry n fetched by dma holds inverted n per channel
`timescale 1ns/100ps
`default_nettype none
module tb;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} lgl_row_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, frame_start, px_valid;
    logic lcd_valid, dma_req, dma_ack, dma_rvalid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, dma_addr, dma_rdata, rd;
    logic [23:0] video_rgb, lcd_rgb, got_rgb;
    logic [15:0] got_cnt;
    logic [7:0]  gfx_index;
    logic        er;
    int bad_count, tests_run, cyc;
    lgl_row_s rows[7] = '{'{12'h004, 32'h0C000001, 32'h0C000001, 1'b0},
        '{12'h008, 32'h12345678, 32'h12345678, 1'b0}, '{12'h00C, 32'hFFFFFFFF, 32'h0FFF07FF, 1'b0},
        '{12'h010, 32'hFFFFFFFF, 32'h000000FF, 1'b0}, '{12'h000, 32'hFFFFFFFF, 32'h0000000F, 1'b0},
        '{12'h024, 32'h00000001, 32'h00000000, 1'b1}, '{12'h01C, 32'h00000003, 32'h00000000, 1'b1}};
    lgl_top lgl_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_start(frame_start), .px_valid(px_valid),
        .video_rgb(video_rgb), .gfx_index(gfx_index), .lcd_valid(lcd_valid), .lcd_rgb(lcd_rgb),
        .dma_req(dma_req), .dma_addr(dma_addr), .dma_ack(dma_ack), .dma_rvalid(dma_rvalid),
        .dma_rdata(dma_rdata));
    lgl_panel lgl_panel_i (.pclk(pclk), .presetn(presetn), .lcd_valid(lcd_valid),
        .lcd_rgb(lcd_rgb), .got_rgb(got_rgb), .got_cnt(got_cnt));
    // clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    // memory answering fetches: ack one cycle, data the next, noise otherwise
    always @(posedge pclk) begin
        dma_ack <= dma_req & ~dma_ack;
        dma_rvalid <= dma_ack;
        dma_rdata <= dma_ack ? {8'h00, ~{3{dma_addr[9:2]}}} : ~dma_rdata;
    end
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            $display("ERROR %s expected %h seen %h", n, x, g);
            bad_count++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the answer; only the bench timeout ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic pix(input logic [23:0] v, input logic [7:0] i, input logic [23:0] x);
        logic [15:0] c;
        c = got_cnt;
        px_valid <= 1'b1;
        video_rgb <= v;
        gfx_index <= i;
        @(posedge pclk);
        px_valid <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("pixel count", 32'(c + 16'h0001), 32'(got_cnt));
        chk("pixel", 32'(x), 32'(got_rgb));
    endtask
    task automatic frame(input logic fetch);
        logic seen;
        seen = 1'b0;
        frame_start <= 1'b1;
        @(posedge pclk);
        frame_start <= 1'b0;
        repeat (4) begin
            @(posedge pclk);
            seen = seen | (dma_req === 1'b1);
        end
        chk("fetch start", 32'(fetch), 32'(seen));
        for (int k = 0; k < 1000 && fetch; k++) begin
            apb(1'b0, 12'h01C, 32'h0);
            if (rd[1] === 1'b0) break;
        end
        if (fetch) chk("fetch end", 32'h0, 32'(rd[1]));
    endtask
    task automatic test_done();
        $display("tests %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // main sequence
    initial begin
        {psel, penable, pwrite, frame_start, px_valid, presetn} = 6'h00;
        {paddr, pwdata, video_rgb, gfx_index} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[k]) begin
            apb(1'b1, rows[k].a, rows[k].d);
            chk("write error", 32'(rows[k].e), 32'(er));
            apb(1'b0, rows[k].a, 32'h0);
            if (!rows[k].e) chk("readback", rows[k].x, rd);
        end
        $display("register table done");
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int k = 0; k < 9; k++) begin
            apb(1'b0, 12'(4 * k), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        $display("reset test done");
        apb(1'b1, 12'h004, 32'h00000001);
        apb(1'b1, 12'h008, 32'h00002000);
        apb(1'b1, 12'h00C, 32'h00010001);
        apb(1'b1, 12'h010, 32'h00000000);
        apb(1'b1, 12'h000, 32'h00000008);
        apb(1'b1, 12'h014, 32'h00000010);
        apb(1'b1, 12'h018, 32'h00110000);
        apb(1'b1, 12'h004, 32'h00000000);
        apb(1'b1, 12'h014, 32'h00000010);
        apb(1'b1, 12'h018, 32'h00AA0000);
        apb(1'b1, 12'h004, 32'h00000001);
        pix(24'h101010, 8'h10, 24'h110000);
        apb(1'b1, 12'h000, 32'h00000000);
        apb(1'b1, 12'h004, 32'h04000001);
        pix(24'h345678, 8'h10, 24'h345678);
        apb(1'b1, 12'h010, 32'h00000080);
        pix(24'h330000, 8'h10, 24'h220000);
        $display("software table test done");
        apb(1'b1, 12'h004, 32'h00000001);
        apb(1'b1, 12'h010, 32'h00000000);
        apb(1'b1, 12'h020, 32'h00001000);
        apb(1'b1, 12'h000, 32'h00000008);
        frame(1'b1);
        apb(1'b0, 12'h01C, 32'h0);
        chk("status", 32'h1, rd);
        pix(24'h102030, 8'h00, 24'hEFDFCF);
        frame(1'b1);
        apb(1'b1, 12'h000, 32'h0000000A);
        frame(1'b0);
        $display("fetch test done");
        test_done();
    end
endmodule
`default_nettype wire
